// ---- shared/fac_regs.vh ----
// Summary of operation
// - only mode codes 01 and 10 ever written
// - programming-mode flash writes are half-words only
// - no flash writes while ROM mode selected (the S_RST reset write after a hang is issued in ROM mode too)
// - programming mode: no fetches, interrupts held off
// - mode changes issued from logic outside flash
// - dummy readback after each config register write
// - dummy flash read after each embedded command
// - read-wait 00 only at 60 MHz or below
// - first status read after command is discarded
// - slow-down codes 000,001,011,101,111 add 0,1,3,5,7
// - no low-power entry while programming mode selected
// - low-power only after embedded operation finished
// - block watchdog resets during program or erase
`ifndef FAC_REGS_VH
`define FAC_REGS_VH

// wishbone map of the controller (byte addresses)
`define FAC_WB_CMD 8'h00
`define FAC_WB_ARG 8'h04
`define FAC_WB_ADDR 8'h08
`define FAC_WB_STAT 8'h0c
`define FAC_WB_RDAT 8'h10

// device register space indices
`define FAC_DEV_ASZ 20'h00000
`define FAC_DEV_RWT 20'h00004
`define FAC_DEV_STR 20'h00008
`define FAC_DEV_SDN 20'h0000c

`define FAC_ASZ_ROM 2'b10
`define FAC_ASZ_PROG 2'b01
`define FAC_ASZ_RST 2'b10
`define FAC_RWT_RST 2'b10
`define FAC_SDN_RST 3'b000
`define FAC_HSIZE_HALF 2'b01
`define FAC_HSIZE_WORD 2'b10
`define FAC_STR_HANG 1
`define FAC_STR_RDY 0

// command codes in the cmd register
`define FAC_OP_CLR 3'h0
`define FAC_OP_MODE 3'h1
`define FAC_OP_RWAIT 3'h2
`define FAC_OP_SDOWN 3'h3
`define FAC_OP_FWRITE 3'h4
`define FAC_OP_FREAD 3'h5
`define FAC_OP_STATUS 3'h6
`define FAC_OP_FRESET 3'h7

`define FAC_RESET_CMD 16'h00f0
`define FAC_RWT0_MAX_MHZ 60
`define FAC_CPU_MHZ 40
`define FAC_CLK_NS 25
`define FAC_POLL_NS 1000
`define FAC_POLL_CYC ((`FAC_POLL_NS + `FAC_CLK_NS - 1) / `FAC_CLK_NS)
`define FAC_MAX_POLLS 16'd4000

`endif

// ---- design/fac_dev_master.v ----
`timescale 1ns/100ps
`default_nettype none
`include "fac_regs.vh"
module fac_dev_master (
  input wire ref_clk, // clock
  input wire srst, // sync reset
  input wire start, // one-cycle access request
  input wire reg_sel, // 1 register space, 0 flash array
  input wire we, // write access
  input wire [19:0] addr, // access address
  input wire [1:0] hsize, // access size
  input wire [31:0] wdata, // write data
  output wire busy, // access in flight
  output reg done, // one-cycle completion pulse
  output reg [31:0] rdata, // captured read data
  output reg dev_req, // request to device
  output reg dev_reg, // register space select
  output reg dev_we, // write strobe
  output reg [19:0] dev_addr, // address
  output reg [1:0] dev_hsize, // size
  output reg [31:0] dev_wdata, // write data
  input wire [31:0] dev_rdata, // read data
  input wire dev_ack // access complete
);
  assign busy = dev_req;

  // request held stable until the device acknowledges
  always @(posedge ref_clk) begin
    if (srst) begin
      dev_req <= 1'b0;
      dev_reg <= 1'b0;
      dev_we <= 1'b0;
      dev_addr <= 20'h00000;
      dev_hsize <= `FAC_HSIZE_WORD;
      dev_wdata <= 32'h00000000;
      done <= 1'b0;
      rdata <= 32'h00000000;
    end else begin
      done <= 1'b0;
      if (dev_req) begin
        if (dev_ack) begin
          dev_req <= 1'b0;
          dev_we <= 1'b0;
          done <= 1'b1;
          rdata <= dev_rdata;
        end
      end else if (start) begin
        dev_req <= 1'b1;
        dev_reg <= reg_sel;
        dev_we <= we;
        dev_addr <= addr;
        dev_hsize <= hsize;
        dev_wdata <= wdata;
      end
    end
  end
endmodule
`default_nettype wire

// ---- design/fac_poll_timer.v ----
`timescale 1ns/100ps
`default_nettype none
module fac_poll_timer #(
  parameter WAIT = 40,
  parameter W = 16
) (
  input wire ref_clk, // clock
  input wire srst, // sync reset
  input wire start, // begin interval
  output reg expire // one-cycle pulse at interval end
);
  localparam [W-1:0] LOAD = WAIT - 1;
  reg [W-1:0] cnt_r;
  reg run_r;

  always @(posedge ref_clk) begin
    if (srst) begin
      cnt_r <= {W{1'b0}};
      run_r <= 1'b0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (start) begin
        cnt_r <= LOAD;
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cnt_r == {W{1'b0}}) begin
          run_r <= 1'b0;
          expire <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- design/fac_host.v ----
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "fac_regs.vh"
module fac_host #(
  parameter CPU_MHZ = `FAC_CPU_MHZ,
  parameter POLL_CYC = `FAC_POLL_CYC,
  parameter [15:0] MAX_POLLS = `FAC_MAX_POLLS,
  parameter [15:0] RESET_CMD = `FAC_RESET_CMD
) (
  input wire ref_clk, // 40 MHz clock
  input wire srst, // sync reset, active high
  input wire wb_cyc_i, // wishbone cycle
  input wire wb_stb_i, // wishbone strobe
  input wire wb_we_i, // wishbone write
  input wire [7:0] wb_adr_i, // byte address
  input wire [3:0] wb_sel_i, // byte lanes
  input wire [31:0] wb_dat_i, // write data
  output reg [31:0] wb_dat_o, // read data
  output wire wb_ack_o, // acknowledge
  output wire dev_req, // device access request
  output wire dev_reg, // 1 register space, 0 flash array
  output wire dev_we, // write access
  output wire [19:0] dev_addr, // address
  output wire [1:0] dev_hsize, // access size
  output wire [31:0] dev_wdata, // write data
  input wire [31:0] dev_rdata, // read data
  input wire dev_ack, // device access done
  input wire lp_req, // system asks for low power
  output reg lp_grant, // low power allowed
  output reg irq_hold, // keep interrupt sources masked
  output reg fetch_block, // forbid instruction fetch from flash
  output reg wdt_hold // hold off watchdog reset
);
  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_WR = 9'h002;
  localparam [8:0] S_RB = 9'h004;
  localparam [8:0] S_DUM = 9'h008;
  localparam [8:0] S_RD = 9'h010;
  localparam [8:0] S_ST1 = 9'h020;
  localparam [8:0] S_ST = 9'h040;
  localparam [8:0] S_WAIT = 9'h080;
  localparam [8:0] S_RST = 9'h100;

  reg [8:0] state_r;
  reg [2:0] op_r;
  reg [15:0] arg_r;
  reg [19:0] addr_r;
  reg [31:0] rdat_r;
  reg [1:0] mode_r;
  reg err_r;
  reg hang_r;
  reg ready_r;
  reg cmd_pend_r;
  reg stale_r;
  reg issued_r;
  reg ack_r;
  reg [15:0] polls_r;
  reg [19:0] acc_addr;
  reg [31:0] acc_wdata;
  reg acc_reg;
  reg acc_we;
  reg [1:0] acc_hsize;
  reg acc_state;
  wire mst_busy;
  wire mst_done;
  wire [31:0] mst_rdata;
  wire tmr_exp;
  wire tmr_start;
  wire wr_hit;
  wire cmd_wr;
  wire [2:0] new_op;

  // legal slow-down codes: 000 or any odd code
  function sdn_ok;
    input [2:0] c;
    begin
      sdn_ok = (c == 3'b000) || c[0];
    end
  endfunction

  function op_ok;
    input [2:0] o;
    input [15:0] a;
    input [1:0] m;
    input rdy;
    begin
      case (o)
        `FAC_OP_MODE: op_ok = (a[1:0] == `FAC_ASZ_PROG) ||
          (a[1:0] == `FAC_ASZ_ROM);
        `FAC_OP_RWAIT: op_ok = (a[1:0] == `FAC_RWT_RST) ||
          (a[1:0] == 2'b00 && CPU_MHZ <= `FAC_RWT0_MAX_MHZ);
        `FAC_OP_SDOWN: op_ok = sdn_ok(a[2:0]);
        `FAC_OP_FWRITE: op_ok = (m == `FAC_ASZ_PROG) && rdy;
        `FAC_OP_FRESET: op_ok = (m == `FAC_ASZ_PROG);
        default: op_ok = 1'b1;
      endcase
    end
  endfunction

  assign wb_ack_o = ack_r;
  // write takes effect at the edge where the master sees ack high
  assign wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
  assign cmd_wr = wr_hit && wb_adr_i == `FAC_WB_CMD && wb_sel_i[0];
  assign new_op = wb_dat_i[2:0];

  always @(posedge ref_clk) begin
    if (srst) begin
      ack_r <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
      if (wb_cyc_i & wb_stb_i & ~ack_r) begin
        if (wb_adr_i == `FAC_WB_CMD) begin
          wb_dat_o <= {29'h0000000, op_r};
        end else if (wb_adr_i == `FAC_WB_ARG) begin
          wb_dat_o <= {16'h0000, arg_r};
        end else if (wb_adr_i == `FAC_WB_ADDR) begin
          wb_dat_o <= {12'h000, addr_r};
        end else if (wb_adr_i == `FAC_WB_STAT) begin
          wb_dat_o <= {21'h000000, lp_grant, irq_hold, wdt_hold, stale_r,
            cmd_pend_r, mode_r, hang_r, ready_r, err_r, ~state_r[0]};
        end else if (wb_adr_i == `FAC_WB_RDAT) begin
          wb_dat_o <= rdat_r;
        end else begin
          wb_dat_o <= 32'h00000000;
        end
      end
    end
  end

  // per-state device access
  always @* begin
    acc_state = 1'b1;
    acc_reg = 1'b1;
    acc_we = 1'b0;
    acc_addr = `FAC_DEV_STR;
    acc_hsize = `FAC_HSIZE_WORD;
    acc_wdata = 32'h00000000;
    case (state_r)
      S_WR: begin
        acc_we = 1'b1;
        case (op_r)
          `FAC_OP_MODE: begin
            acc_addr = `FAC_DEV_ASZ;
            acc_wdata = {30'h00000000, arg_r[1:0]};
          end
          `FAC_OP_RWAIT: begin
            acc_addr = `FAC_DEV_RWT;
            // low bit is fixed inside the device
            acc_wdata = {30'h00000000, arg_r[1], 1'b0};
          end
          `FAC_OP_SDOWN: begin
            acc_addr = `FAC_DEV_SDN;
            acc_wdata = {29'h00000000, arg_r[2:0]};
          end
          default: begin
            acc_reg = 1'b0;
            acc_addr = addr_r;
            acc_hsize = `FAC_HSIZE_HALF;
            acc_wdata = {16'h0000, arg_r};
          end
        endcase
      end
      S_RB: begin
        case (op_r)
          `FAC_OP_MODE: acc_addr = `FAC_DEV_ASZ;
          `FAC_OP_RWAIT: acc_addr = `FAC_DEV_RWT;
          default: acc_addr = `FAC_DEV_SDN;
        endcase
      end
      S_DUM, S_RD: begin
        acc_reg = 1'b0;
        acc_addr = addr_r;
      end
      S_ST1, S_ST: acc_addr = `FAC_DEV_STR;
      S_RST: begin
        acc_reg = 1'b0;
        acc_we = 1'b1;
        acc_addr = addr_r;
        acc_hsize = `FAC_HSIZE_HALF;
        acc_wdata = {16'h0000, RESET_CMD};
      end
      default: acc_state = 1'b0;
    endcase
  end

  assign tmr_start = (state_r == S_ST) && mst_done &&
    !mst_rdata[`FAC_STR_HANG] && !mst_rdata[`FAC_STR_RDY];

  always @(posedge ref_clk) begin
    if (srst) begin
      state_r <= S_IDLE;
      op_r <= `FAC_OP_CLR;
      arg_r <= 16'h0000;
      addr_r <= 20'h00000;
      rdat_r <= 32'h00000000;
      mode_r <= `FAC_ASZ_RST;
      err_r <= 1'b0;
      hang_r <= 1'b0;
      ready_r <= 1'b1;
      cmd_pend_r <= 1'b0;
      stale_r <= 1'b0;
      issued_r <= 1'b0;
      polls_r <= 16'h0000;
    end else begin
      if (wr_hit && wb_adr_i == `FAC_WB_ARG) begin
        arg_r <= wb_dat_i[15:0];
      end
      if (wr_hit && wb_adr_i == `FAC_WB_ADDR) begin
        addr_r <= wb_dat_i[19:0];
      end
      if (acc_state && !issued_r && !mst_busy) begin
        issued_r <= 1'b1;
      end
      if (mst_done) begin
        issued_r <= 1'b0;
      end
      case (state_r)
        S_IDLE: begin
          if (cmd_wr) begin
            op_r <= new_op;
            polls_r <= 16'h0000;
            if (new_op == `FAC_OP_CLR) begin
              err_r <= 1'b0;
            end else if (!op_ok(new_op, arg_r, mode_r, ready_r)) begin
              err_r <= 1'b1;
            end else if (new_op == `FAC_OP_FREAD) begin
              state_r <= cmd_pend_r ? S_DUM : S_RD;
            end else if (new_op == `FAC_OP_STATUS) begin
              state_r <= stale_r ? S_ST1 : S_ST;
            end else if (new_op == `FAC_OP_FRESET) begin
              state_r <= S_RST;
            end else begin
              state_r <= S_WR;
            end
          end
        end
        S_WR: begin
          if (mst_done) begin
            if (op_r == `FAC_OP_FWRITE) begin
              // command written: device now busy, next reads unreliable
              cmd_pend_r <= 1'b1;
              stale_r <= 1'b1;
              ready_r <= 1'b0;
              state_r <= S_IDLE;
            end else begin
              state_r <= S_RB;
            end
          end
        end
        S_RB: begin
          if (mst_done) begin
            if (op_r == `FAC_OP_MODE) begin
              mode_r <= arg_r[1:0];
            end
            rdat_r <= mst_rdata;
            state_r <= S_IDLE;
          end
        end
        S_DUM: begin
          if (mst_done) begin
            cmd_pend_r <= 1'b0;
            state_r <= S_RD;
          end
        end
        S_RD: begin
          if (mst_done) begin
            rdat_r <= mst_rdata;
            state_r <= S_IDLE;
          end
        end
        S_ST1: begin
          if (mst_done) begin
            stale_r <= 1'b0;
            state_r <= S_ST;
          end
        end
        S_ST: begin
          if (mst_done) begin
            // bits 7:2 are undefined and never looked at
            rdat_r <= {30'h00000000, mst_rdata[1:0]};
            hang_r <= mst_rdata[`FAC_STR_HANG];
            ready_r <= mst_rdata[`FAC_STR_RDY];
            polls_r <= polls_r + 16'h0001;
            if (mst_rdata[`FAC_STR_HANG]) begin
              state_r <= S_RST;
            end else if (mst_rdata[`FAC_STR_RDY]) begin
              state_r <= S_IDLE;
            end else if (polls_r == MAX_POLLS) begin
              err_r <= 1'b1;
              state_r <= S_IDLE;
            end else begin
              state_r <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          if (tmr_exp) begin
            state_r <= S_ST;
          end
        end
        S_RST: begin
          if (mst_done) begin
            cmd_pend_r <= 1'b1;
            stale_r <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // system-side guards around programming
  always @(posedge ref_clk) begin
    if (srst) begin
      lp_grant <= 1'b0;
      irq_hold <= 1'b0;
      fetch_block <= 1'b0;
      wdt_hold <= 1'b0;
    end else begin
      irq_hold <= (mode_r == `FAC_ASZ_PROG);
      fetch_block <= (mode_r == `FAC_ASZ_PROG);
      wdt_hold <= (mode_r == `FAC_ASZ_PROG) || !ready_r;
      lp_grant <= lp_req && (mode_r == `FAC_ASZ_ROM) &&
        ready_r && state_r[0];
    end
  end

  // this controller is fabric logic, so mode writes never come from flash
  fac_dev_master u_mst (
    .ref_clk(ref_clk),
    .srst(srst),
    .start(acc_state && !issued_r && !mst_busy),
    .reg_sel(acc_reg),
    .we(acc_we),
    .addr(acc_addr),
    .hsize(acc_hsize),
    .wdata(acc_wdata),
    .busy(mst_busy),
    .done(mst_done),
    .rdata(mst_rdata),
    .dev_req(dev_req),
    .dev_reg(dev_reg),
    .dev_we(dev_we),
    .dev_addr(dev_addr),
    .dev_hsize(dev_hsize),
    .dev_wdata(dev_wdata),
    .dev_rdata(dev_rdata),
    .dev_ack(dev_ack)
  );

  fac_poll_timer #(
    .WAIT(POLL_CYC),
    .W(16)
  ) u_tmr (
    .ref_clk(ref_clk),
    .srst(srst),
    .start(tmr_start),
    .expire(tmr_exp)
  );
endmodule
`default_nettype wire

// ---- tb/fac_host_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module fac_host_chk (
  input wire logic ref_clk, // clock
  input wire logic srst, // sync reset
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_ack_o, // bus acknowledge
  input wire logic dev_req, // device request
  input wire logic dev_reg, // register space
  input wire logic dev_we, // device write
  input wire logic [19:0] dev_addr, // device address
  input wire logic [1:0] dev_hsize, // device size
  input wire logic [31:0] dev_wdata, // device write data
  input wire logic dev_ack, // device done
  input wire logic lp_grant, // low power allowed
  input wire logic irq_hold, // interrupts held
  input wire logic fetch_block, // fetch blocked
  input wire logic wdt_hold // watchdog held
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_bus_req;
    $rose(wb_cyc_i && wb_stb_i);
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_once: assert property (s_bus_req |=> s_ack_pulse)
    else $error("bus ack not one pulse after request");
  a_req_hold: assert property (dev_req && !dev_ack |=> dev_req &&
    $stable({dev_reg, dev_we, dev_addr, dev_hsize, dev_wdata}))
    else $error("device request changed before ack");
  a_req_drop: assert property (dev_ack |=> !dev_req)
    else $error("device request held after ack");
  a_half_write: assert property (dev_req && dev_we && !dev_reg |->
    dev_hsize == 2'b01) else $error("flash write not half-word");
  a_rom_nowrite: assert property (dev_req && dev_we && !dev_reg |->
    fetch_block) else $error("flash write outside programming mode");
  a_irq_fetch: assert property (irq_hold == fetch_block)
    else $error("interrupt hold differs from fetch block");
  a_wdt_prog: assert property (fetch_block |-> wdt_hold)
    else $error("watchdog free in programming mode");
  a_lp_prog: assert property (lp_grant |-> !fetch_block)
    else $error("low power granted in programming mode");
  a_lp_busy: assert property (lp_grant |-> !wdt_hold)
    else $error("low power granted while operation runs");
endmodule
bind fac_host fac_host_chk i_fac_host_chk (.*);
`default_nettype wire

// ---- tb/fac_dev_model.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "fac_regs.vh"
module fac_dev_model (
  input wire logic ref_clk, // clock
  input wire logic srst, // sync reset
  input wire logic dev_req, // access request
  input wire logic dev_reg, // register space
  input wire logic dev_we, // write
  input wire logic [19:0] dev_addr, // address
  input wire logic [1:0] dev_hsize, // size
  input wire logic [31:0] dev_wdata, // write data
  output logic [31:0] dev_rdata, // read data
  output logic dev_ack, // done pulse
  input wire logic slow, // longer answers
  input wire logic hang_en, // next program hangs
  output logic [1:0] access_size_field, // access size
  output logic [1:0] read_wait_field, // read wait
  output logic [2:0] sdn, // slow down
  output logic [15:0] mem, // last programmed half-word
  output logic rdy, // ready
  output logic got_rst // reset command seen
);
  logic hang, pend, stale, act;
  logic [4:0] cnt;
  logic [5:0] bsy;
  logic [31:0] rd;
  always @(posedge ref_clk) begin
    dev_ack <= 1'b0;
    // released data keeps toggling so a late sample cannot pass
    dev_rdata <= ~dev_rdata;
    if (bsy != 6'h00 && !hang) bsy <= bsy - 6'h01;
    if (bsy == 6'h01 && !hang) rdy <= 1'b1;
    if (srst) begin
      access_size_field <= 2'b10;
      read_wait_field <= 2'b10;
      sdn <= 3'b000;
      {rdy, hang, pend, stale, act, got_rst} <= 6'h20;
      {cnt, bsy, mem, dev_rdata} <= '0;
    end else if (dev_req && !dev_ack) begin
      if (!act) begin
        act <= 1'b1;
        cnt <= (slow ? 5'h03 : 5'h00) + ((!dev_reg && !dev_we &&
          access_size_field == 2'b10) ? {3'h0, read_wait_field} + {2'h0, sdn} : 5'h00);
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end else begin
        act <= 1'b0;
        dev_ack <= 1'b1;
        rd = {16'h0000, mem};
        if (dev_reg) begin
          case (dev_addr)
            `FAC_DEV_ASZ: rd = {30'h0, access_size_field};
            `FAC_DEV_RWT: rd = {30'h0, read_wait_field};
            `FAC_DEV_STR: rd = {24'h0, 6'h2a,
              stale ? 2'b01 : {hang, rdy}};
            `FAC_DEV_SDN: rd = {29'h0, sdn};
            default: rd = 32'h0;
          endcase
          // status writes fall to default and are dropped
          if (dev_we) case (dev_addr)
            `FAC_DEV_ASZ: access_size_field <= dev_wdata[1:0];
            `FAC_DEV_RWT: read_wait_field <= {dev_wdata[1], 1'b0};
            `FAC_DEV_SDN: sdn <= dev_wdata[2:0];
            default: ;
          endcase
          if (dev_addr == `FAC_DEV_STR) stale <= 1'b0;
        end else if (dev_we && dev_wdata[15:0] == `FAC_RESET_CMD) begin
          {got_rst, hang, rdy, bsy} <= 9'h140;
        end else if (dev_we) begin
          mem <= dev_wdata[15:0];
          {rdy, pend, stale, hang} <= {3'b011, hang_en};
          bsy <= 6'd30;
        end else begin
          if (pend) rd = ~rd;
          pend <= 1'b0;
        end
        dev_rdata <= rd;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/test_fac_host.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "fac_regs.vh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module test_fac_host;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, lp_req = 1'b0;
  logic slow = 1'b0, hang_en = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, rdat, st;
  logic [31:0] wb_dat_o, dev_wdata, dev_rdata;
  logic wb_ack_o, dev_req, dev_reg, dev_we, dev_ack, lp_grant;
  logic irq_hold, fetch_block, wdt_hold, rdy, got_rst;
  logic [19:0] dev_addr;
  logic [1:0] dev_hsize, access_size_field, read_wait_field;
  logic [2:0] sdn;
  logic [15:0] mem;
  int n_fail = 0, checks = 0, ticks = 0, k;
  fac_host #(.POLL_CYC(4), .MAX_POLLS(16'd8)) i_fac_host (.*);
  fac_dev_model i_fac_dev_model (.*);
  initial forever #12.5 ref_clk = ~ref_clk;
  task results;
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    ticks++;
    if (ticks == 10000) begin
      n_fail++;
      $display("run timed out");
      results;
    end
  end
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 4'hf};
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  // issue one command and wait until the controller is idle again
  task run(input logic [2:0] op, input logic [15:0] arg);
    int i;
    wb(1'b1, `FAC_WB_ARG, {16'h0, arg});
    wb(1'b1, `FAC_WB_CMD, {29'h0, op});
    st = 32'h1;
    for (i = 0; i < 400 && st[0] !== 1'b0; i++) begin
      wb(1'b0, `FAC_WB_STAT, 32'h0);
      st = rdat;
    end
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    wb(1'b0, `FAC_WB_STAT, 32'h0);
    `CHK("mode", 2'b10, rdat[5:4])
    `CHK("ready", 1'b1, rdat[2])
    `CHK("dev mode", 2'b10, access_size_field)
    wb(1'b1, 8'h14, 32'hffff_ffff);
    wb(1'b0, 8'h14, 32'h0);
    `CHK("unmapped", 32'h0, rdat)
    $display("reset test done");
    for (k = 0; k < 4; k++) begin
      run(`FAC_OP_MODE, k[15:0]);
      `CHK("mode err", k == 0 || k == 3, st[1])
      run(`FAC_OP_CLR, 16'h0);
    end
    `CHK("mode kept", 2'b10, access_size_field)
    wb(1'b1, `FAC_WB_ADDR, 32'h100);
    run(`FAC_OP_FWRITE, 16'h1234);
    `CHK("rom write err", 1'b1, st[1])
    `CHK("rom write", 16'h0, mem)
    run(`FAC_OP_CLR, 16'h0);
    run(`FAC_OP_FRESET, 16'h0);
    `CHK("rom reset err", 1'b1, st[1])
    `CHK("rom reset", 1'b0, got_rst)
    run(`FAC_OP_CLR, 16'h0);
    run(`FAC_OP_MODE, 16'h1);
    `CHK("prog mode", 2'b01, st[5:4])
    `CHK("fetch", 1'b1, fetch_block)
    `CHK("irq", 1'b1, irq_hold)
    `CHK("wdt", 1'b1, wdt_hold)
    lp_req <= 1'b1;
    repeat (3) @(posedge ref_clk);
    `CHK("lp prog", 1'b0, lp_grant)
    $display("mode test done");
    run(`FAC_OP_FWRITE, 16'hbeef);
    `CHK("written", 16'hbeef, mem)
    `CHK("busy", 1'b0, st[2])
    `CHK("pend", 1'b1, st[6])
    `CHK("stale", 1'b1, st[7])
    run(`FAC_OP_STATUS, 16'h0);
    `CHK("dev ready", 1'b1, rdy)
    `CHK("ready", 1'b1, st[2])
    `CHK("stale clr", 1'b0, st[7])
    run(`FAC_OP_FREAD, 16'h0);
    wb(1'b0, `FAC_WB_RDAT, 32'h0);
    `CHK("read", 32'h0000beef, rdat)
    `CHK("pend clr", 1'b0, st[6])
    $display("program test done");
    slow <= 1'b1;
    hang_en <= 1'b1;
    run(`FAC_OP_FWRITE, 16'h5a5a);
    run(`FAC_OP_FWRITE, 16'h1111);
    `CHK("busy write err", 1'b1, st[1])
    `CHK("busy write", 16'h5a5a, mem)
    run(`FAC_OP_CLR, 16'h0);
    run(`FAC_OP_STATUS, 16'h0);
    `CHK("reset cmd", 1'b1, got_rst)
    `CHK("recovered", 1'b1, rdy)
    `CHK("hang seen", 1'b1, st[3])
    run(`FAC_OP_STATUS, 16'h0);
    `CHK("hang clr", 1'b0, st[3])
    `CHK("ready back", 1'b1, st[2])
    hang_en <= 1'b0;
    $display("hang test done");
    run(`FAC_OP_MODE, 16'h2);
    repeat (3) @(posedge ref_clk);
    `CHK("lp rom", 1'b1, lp_grant)
    `CHK("fetch rom", 1'b0, fetch_block)
    for (k = 0; k < 4; k++) begin
      run(`FAC_OP_RWAIT, k[15:0]);
      `CHK("rwt err", k[0], st[1])
      if (!k[0]) `CHK("rwt", k[1:0], read_wait_field)
      run(`FAC_OP_CLR, 16'h0);
    end
    for (k = 0; k < 8; k++) begin
      run(`FAC_OP_SDOWN, k[15:0]);
      `CHK("sd err", k != 0 && !k[0], st[1])
      if (k == 0 || k[0]) `CHK("sd", k[2:0], sdn)
      run(`FAC_OP_CLR, 16'h0);
    end
    run(`FAC_OP_FREAD, 16'h0);
    wb(1'b0, `FAC_WB_RDAT, 32'h0);
    `CHK("rom read", 32'h00005a5a, rdat)
    $display("wait test done");
    results;
  end
endmodule
`default_nettype wire
